// file: rtl/csd_pkg.sv
// Package: register map, field layout, reset values and bus carriers of the clock control block
package csd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLK_OUT_CTRL = 8'h8E;
  localparam logic [7:0] IDX_DIVIDER = 8'h95;
  localparam logic [7:0] IDX_CLK_SWITCH = 8'h96;
  localparam logic [7:0] IDX_SRC_ENABLE = 8'h97;
  localparam logic [7:0] IDX_TA_KEY = 8'hC7;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF1;

  // Reset values
  localparam logic [7:0] CLK_OUT_CTRL_RESET = 8'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h00;
  localparam logic [7:0] SRC_ENABLE_RESET = 8'h30;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Writable bits of the clock output and timer clock control register
  localparam logic [7:0] CLK_OUT_CTRL_WMASK = 8'h5A;

  // Field positions
  localparam int SYSCLK_OUT_EN_BIT = 1;
  localparam int EXT_EN_LSB = 6;
  localparam int FAST_EN_BIT = 5;
  localparam int RSVD_ONE_BIT = 4;
  localparam int FAULT_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int FAST_ST_BIT = 5;
  localparam int SLOW_ST_BIT = 4;
  localparam int EXT_ST_BIT = 3;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_SWITCH_BIT = 1;
  localparam int IRQ_BITS = 2;

  localparam logic [1:0] EXT_ENABLE_CODE = 2'h3;
  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;

  // Unlock window after the second key byte
  localparam int CLK_PERIOD_NS = 10;
  localparam int TA_WINDOW_NS = 160;
  localparam logic [4:0] TA_WINDOW_CYC = 5'(TA_WINDOW_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    CSD_SRC_FAST = 2'b00,
    CSD_SRC_EXT = 2'b01,
    CSD_SRC_SLOW = 2'b10,
    CSD_SRC_RSVD = 2'b11
  } csd_src_t;

  typedef enum logic [1:0] {
    CSD_TA_LOCKED = 2'b00,
    CSD_TA_HALF = 2'b01,
    CSD_TA_OPEN = 2'b10
  } csd_ta_t;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } csd_wb_req_t;

  // Readiness of the analog clock sources
  typedef struct packed {
    logic fast_ready;
    logic slow_ready;
    logic ext_ready;
  } csd_osc_ready_t;

endpackage

// file: rtl/csd_clock_ctrl.sv
// Module: system clock source select, divider and clock output with Wishbone register access
// What this block does
// - Enable external clock pin only on code 11
// - Fast enable bit 5 switches fast oscillator
// - Programming forces fast oscillator, enable, stable
// - Programming off restores fast enable, stable
// - Fault flag bit 0 shows last switch result
// - Fault stays set until pending switch completes
// - Divider 00 passes, else divides by 2N
// - Divider writes accepted anytime without stalling
// - Output enable bit drives clock out pin
// - Output pin runs at divided system rate
// - Power-down halts system clock and output
// - Enable register writes need timed-access unlock
// - Select code picks fast, external, slow source
// - Disabling the active source is ignored, except the fast source during programming
// - Selecting disabled source sets fault, no switch
// - Unstable target switches once stable, clears fault
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module csd_clock_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire csd_pkg::csd_wb_req_t wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire csd_pkg::csd_osc_ready_t osc_ready_i,
  input wire logic in_app_program_enable_i,
  input wire logic power_down_i,
  output logic fast_osc_on_o,
  output logic ext_clock_pin_en_o,
  output logic [1:0] active_source_o,
  output logic sys_tick_o,
  output logic sysclk_out_pin_o,
  output logic sysclk_out_pin_oe_o,
  output logic irq_o
);

  // Source enabled by the current enable settings
  function automatic logic src_enabled(input logic [1:0] src, input logic fast_en, input logic [1:0] ext_en);
    case (src)
      csd_pkg::CSD_SRC_FAST: src_enabled = fast_en;
      csd_pkg::CSD_SRC_EXT: src_enabled = (ext_en == csd_pkg::EXT_ENABLE_CODE);
      csd_pkg::CSD_SRC_SLOW: src_enabled = 1'b1;
      default: src_enabled = 1'b0;
    endcase
  endfunction

  // Source enabled and stable
  function automatic logic src_stable(input logic [1:0] src, input logic [2:0] st);
    case (src)
      csd_pkg::CSD_SRC_FAST: src_stable = st[2];
      csd_pkg::CSD_SRC_EXT: src_stable = st[0];
      csd_pkg::CSD_SRC_SLOW: src_stable = st[1];
      default: src_stable = 1'b0;
    endcase
  endfunction

  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] clk_out_ctrl_q;
  logic [7:0] divider_q;
  logic [7:0] div_active_q;
  logic [7:0] div_cnt_q;
  logic pin_q;
  logic pin_oe_q;
  logic pin_out_q;
  logic pin_toggle;
  logic pin_next;
  logic tick_q;
  logic [1:0] ext_en_q;
  logic fast_en_q;
  logic fault_q;
  csd_pkg::csd_src_t select_q;
  csd_pkg::csd_src_t active_q;
  csd_pkg::csd_ta_t ta_state_q;
  logic [4:0] ta_cnt_q;
  logic [csd_pkg::IRQ_BITS-1:0] irq_status_q;
  logic [csd_pkg::IRQ_BITS-1:0] irq_mask_q;
  logic irq_q;
  logic fast_on_q;
  logic ext_pin_q;

  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic unlocked;
  logic fast_en_eff;
  logic fast_st;
  logic slow_st;
  logic ext_st;
  logic [2:0] st_vec;
  logic clock_source_enable_wr;
  logic clock_source_enable_ok;
  logic swt_wr;
  logic target_ok;
  logic switch_now;
  logic fault_d;
  logic [csd_pkg::IRQ_BITS-1:0] irq_event;
  logic period_end;

  // Bus decode; a request is taken on the edge where ack rises
  assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  assign wr = req & wb_req_i.we & wb_req_i.sel[0];
  assign idx = wb_req_i.adr[9:2];
  assign wbyte = wb_req_i.dat[7:0];
  assign unlocked = (ta_state_q == csd_pkg::CSD_TA_OPEN);

  // Programming overlays the stored enable; clearing it shows the stored bit again
  assign fast_en_eff = fast_en_q | in_app_program_enable_i;
  assign fast_st = in_app_program_enable_i | (fast_en_q & osc_ready_i.fast_ready);
  assign slow_st = osc_ready_i.slow_ready;
  assign ext_st = (ext_en_q == csd_pkg::EXT_ENABLE_CODE) & osc_ready_i.ext_ready;
  assign st_vec = {fast_st, slow_st, ext_st};

  // Refuse an enable write that would stop the running source
  assign clock_source_enable_wr = wr & unlocked & (idx == csd_pkg::IDX_SRC_ENABLE);
  assign clock_source_enable_ok = src_enabled(active_q, wbyte[csd_pkg::FAST_EN_BIT] | in_app_program_enable_i,
                               wbyte[csd_pkg::EXT_EN_LSB +: 2]);
  assign swt_wr = wr & unlocked & (idx == csd_pkg::IDX_CLK_SWITCH);

  assign target_ok = src_enabled(select_q, fast_en_eff, ext_en_q) & src_stable(select_q, st_vec);
  assign switch_now = (select_q != active_q) & target_ok;
  assign fault_d = (select_q != active_q) & ~target_ok;

  assign irq_event[csd_pkg::IRQ_FAULT_BIT] = fault_d & ~fault_q;
  assign irq_event[csd_pkg::IRQ_SWITCH_BIT] = switch_now;

  // Wishbone ack, one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read data, captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else if (req) begin
      case (idx)
        csd_pkg::IDX_CLK_OUT_CTRL: rdata_q <= {24'h000000, clk_out_ctrl_q};
        csd_pkg::IDX_DIVIDER: rdata_q <= {24'h000000, divider_q};
        csd_pkg::IDX_CLK_SWITCH: rdata_q <= {26'h0000000, fast_st, slow_st, ext_st, 3'h0};
        csd_pkg::IDX_SRC_ENABLE: rdata_q <= {24'h000000, ext_en_q, fast_en_eff,
                                             csd_pkg::SRC_ENABLE_RESET[csd_pkg::RSVD_ONE_BIT], 3'h0, fault_q};
        csd_pkg::IDX_IRQ_STATUS: rdata_q <= {30'h0, irq_status_q};
        csd_pkg::IDX_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Timed-access unlock sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ta_state_q <= csd_pkg::CSD_TA_LOCKED;
      ta_cnt_q <= 5'h00;
    end else if (wr & (idx == csd_pkg::IDX_TA_KEY)) begin
      ta_cnt_q <= csd_pkg::TA_WINDOW_CYC;
      if (wbyte == csd_pkg::TA_KEY_FIRST) begin
        ta_state_q <= csd_pkg::CSD_TA_HALF;
      end else if (wbyte == csd_pkg::TA_KEY_SECOND && ta_state_q == csd_pkg::CSD_TA_HALF) begin
        ta_state_q <= csd_pkg::CSD_TA_OPEN;
      end else begin
        ta_state_q <= csd_pkg::CSD_TA_LOCKED;
      end
    end else begin
      case (ta_state_q)
        csd_pkg::CSD_TA_OPEN: begin
          if (clock_source_enable_wr | swt_wr | (ta_cnt_q == 5'h01)) begin
            ta_state_q <= csd_pkg::CSD_TA_LOCKED;
          end
          ta_cnt_q <= ta_cnt_q - 5'h01;
        end
        csd_pkg::CSD_TA_HALF: begin
          if (wr) begin
            ta_state_q <= csd_pkg::CSD_TA_LOCKED;
          end
        end
        default: ta_state_q <= csd_pkg::CSD_TA_LOCKED;
      endcase
    end
  end

  // Clock source enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_en_q <= csd_pkg::SRC_ENABLE_RESET[csd_pkg::EXT_EN_LSB +: 2];
      fast_en_q <= csd_pkg::SRC_ENABLE_RESET[csd_pkg::FAST_EN_BIT];
    end else if (clock_source_enable_wr & clock_source_enable_ok) begin
      ext_en_q <= wbyte[csd_pkg::EXT_EN_LSB +: 2];
      fast_en_q <= wbyte[csd_pkg::FAST_EN_BIT];
    end
  end

  // Source select and background switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_q <= csd_pkg::CSD_SRC_FAST;
      active_q <= csd_pkg::CSD_SRC_FAST;
      fault_q <= 1'b0;
    end else begin
      if (swt_wr) begin
        select_q <= csd_pkg::csd_src_t'(wbyte[csd_pkg::SEL_LSB +: 2]);
      end
      if (switch_now) begin
        active_q <= select_q;
      end
      fault_q <= fault_d;
    end
  end

  // Clock output control and divider registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_ctrl_q <= csd_pkg::CLK_OUT_CTRL_RESET;
      divider_q <= csd_pkg::DIVIDER_RESET;
    end else if (wr) begin
      if (idx == csd_pkg::IDX_CLK_OUT_CTRL) begin
        clk_out_ctrl_q <= wbyte & csd_pkg::CLK_OUT_CTRL_WMASK;
      end
      if (idx == csd_pkg::IDX_DIVIDER) begin
        divider_q <= wbyte;
      end
    end
  end

  // Divider: period ends on each cycle when bypassed, else after the high half
  assign period_end = (div_active_q == 8'h00) | (pin_q & (div_cnt_q == div_active_q - 8'h01));
  // Next divided clock level, mirrors the divider below
  assign pin_toggle = ~power_down_i & ((div_active_q == 8'h00) | (div_cnt_q == div_active_q - 8'h01));
  assign pin_next = pin_q ^ pin_toggle;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_active_q <= csd_pkg::DIVIDER_RESET;
      div_cnt_q <= 8'h00;
      pin_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (power_down_i) begin
      tick_q <= 1'b0;
    end else if (div_active_q == 8'h00) begin
      div_active_q <= divider_q;
      div_cnt_q <= 8'h00;
      pin_q <= ~pin_q;
      tick_q <= 1'b1;
    end else if (div_cnt_q == div_active_q - 8'h01) begin
      div_cnt_q <= 8'h00;
      pin_q <= ~pin_q;
      tick_q <= ~pin_q;
      if (period_end) begin
        div_active_q <= divider_q;
      end
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // Output pin follows the divided clock only while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_oe_q <= 1'b0;
      pin_out_q <= 1'b0;
    end else begin
      pin_oe_q <= clk_out_ctrl_q[csd_pkg::SYSCLK_OUT_EN_BIT];
      pin_out_q <= pin_next & clk_out_ctrl_q[csd_pkg::SYSCLK_OUT_EN_BIT];
    end
  end

  // Interrupt status, write one to clear, set wins
  genvar g;
  generate
    for (g = 0; g < csd_pkg::IRQ_BITS; g++) begin : g_irq
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          irq_status_q[g] <= csd_pkg::IRQ_RESET[g];
        end else if (irq_event[g]) begin
          irq_status_q[g] <= 1'b1;
        end else if (wr && idx == csd_pkg::IDX_IRQ_STATUS && wbyte[g]) begin
          irq_status_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= csd_pkg::IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      if (wr && idx == csd_pkg::IDX_IRQ_MASK) begin
        irq_mask_q <= wbyte[csd_pkg::IRQ_BITS-1:0];
      end
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // Oscillator and pin enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_on_q <= csd_pkg::SRC_ENABLE_RESET[csd_pkg::FAST_EN_BIT];
      ext_pin_q <= 1'b0;
    end else begin
      fast_on_q <= fast_en_eff;
      ext_pin_q <= (ext_en_q == csd_pkg::EXT_ENABLE_CODE);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign fast_osc_on_o = fast_on_q;
  assign ext_clock_pin_en_o = ext_pin_q;
  assign active_source_o = active_q;
  assign sys_tick_o = tick_q;
  assign sysclk_out_pin_o = pin_out_q;
  assign sysclk_out_pin_oe_o = pin_oe_q;
  assign irq_o = irq_q;

endmodule // csd_clock_ctrl

// file: test/csd_clock_ctrl_sva.sv
// Assertion checker for the clock control block
`timescale 1ns/1ps
module csd_clock_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire csd_pkg::csd_wb_req_t wb_req_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire csd_pkg::csd_osc_ready_t osc_ready_i,
  input wire logic in_app_program_enable_i,
  input wire logic power_down_i,
  input wire logic fast_osc_on_o,
  input wire logic ext_clock_pin_en_o,
  input wire logic [1:0] active_source_o,
  input wire logic sys_tick_o,
  input wire logic sysclk_out_pin_o,
  input wire logic sysclk_out_pin_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_answers: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_oe_gates_pin: assert property (!sysclk_out_pin_oe_o |-> !sysclk_out_pin_o)
    else $error("pin active while disabled");
  a_pd_freezes_pin: assert property (power_down_i[*3] ##0 $stable(sysclk_out_pin_oe_o)
    |-> $stable(sysclk_out_pin_o)) else $error("pin toggles in power-down");
  a_ext_switch_ok: assert property ($changed(active_source_o) && active_source_o == 2'h1
    |-> $past(ext_clock_pin_en_o) && $past(osc_ready_i.ext_ready)) else $error("bad switch to ext");
  a_prog_forces_fast: assert property (in_app_program_enable_i |=> fast_osc_on_o)
    else $error("fast osc not forced");
  a_no_reserved_src: assert property (active_source_o != 2'h3) else $error("reserved source");
  a_tick_after_rise: assert property ($rose(sysclk_out_pin_o) && $past(sysclk_out_pin_oe_o) |-> sys_tick_o)
    else $error("no tick with pin rise");
  c_switch: cover property ($changed(active_source_o));
  c_irq: cover property ($rose(irq_o));
  c_pd_out: cover property (power_down_i && sysclk_out_pin_oe_o);
endmodule // csd_clock_ctrl_sva

bind csd_clock_ctrl csd_clock_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .osc_ready_i(osc_ready_i),
  .in_app_program_enable_i(in_app_program_enable_i), .power_down_i(power_down_i),
  .fast_osc_on_o(fast_osc_on_o), .ext_clock_pin_en_o(ext_clock_pin_en_o), .active_source_o(active_source_o),
  .sys_tick_o(sys_tick_o), .sysclk_out_pin_o(sysclk_out_pin_o), .sysclk_out_pin_oe_o(sysclk_out_pin_oe_o),
  .irq_o(irq_o));

// file: test/tb_csd_clock_ctrl.sv
// Testbench for the clock control block
`timescale 1ns/1ps
module tb_csd_clock_ctrl;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  csd_pkg::csd_wb_req_t req = '0;
  csd_pkg::csd_osc_ready_t rdy = 3'h7;
  logic in_app_programming = 1'b0;
  logic pd = 1'b0;
  logic ack, irq, fon, xen, tick, pin, oe;
  logic [31:0] dat;
  logic [1:0] src;
  int n_mismatch = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  csd_clock_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(dat),
    .osc_ready_i(rdy), .in_app_program_enable_i(in_app_programming), .power_down_i(pd), .fast_osc_on_o(fon),
    .ext_clock_pin_en_o(xen), .active_source_o(src), .sys_tick_o(tick), .sysclk_out_pin_o(pin),
    .sysclk_out_pin_oe_o(oe), .irq_o(irq));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [7:0] i, input logic w, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, {i, 2'b00}, 4'h1, {24'h0, d}};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat[7:0];
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    wb(i, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    wb(i, 1'b0, 8'h00, r);
    chk({24'h0, r & m}, {24'h0, e});
  endtask
  task automatic pw(input logic [7:0] i, input logic [7:0] d);
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
    wr(i, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic tk(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (tick !== 1'b1);
  endtask
  task automatic per(input logic [7:0] n);
    int c;
    int h;
    int m;
    wr(8'h95, n);
    repeat (4) tk(c);
    chk(c, (n == 8'h00) ? 1 : 2 * int'(n));
    m = (n == 8'h00) ? 2 : 2 * int'(n);
    h = 0;
    repeat (m) begin
      @(posedge clk_i);
      h += int'(pin === 1'b1);
    end
    chk(h, m / 2);
  endtask
  task automatic t_regs;
    chk({fon, xen, src}, 32'h8);
    rd(8'h8E, 8'hFF, 8'h00);
    rd(8'h95, 8'hFF, 8'h00);
    rd(8'h97, 8'hFF, 8'h30);
    rd(8'h10, 8'hFF, 8'h00);
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'hFF, 8'h5A);
    wr(8'h97, 8'hF0);
    rd(8'h97, 8'hFF, 8'h30);
    pw(8'h97, 8'hF0);
    cyc(2);
    chk(xen, 1);
    pw(8'h97, 8'h70);
    cyc(2);
    chk(xen, 0);
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
    cyc(20);
    wr(8'h97, 8'hF0);
    rd(8'h97, 8'hFF, 8'h70);
  endtask
  task automatic t_switch;
    wr(8'hF1, 8'h01);
    pw(8'h96, 8'h02);
    cyc(3);
    chk(src, 0);
    rd(8'h97, 8'hFF, 8'h71);
    chk(irq, 1);
    wr(8'hF0, 8'h01);
    cyc(2);
    chk(irq, 0);
    rdy.slow_ready <= 1'b0;
    pw(8'h96, 8'h04);
    cyc(3);
    chk(src, 0);
    rd(8'h97, 8'h01, 8'h01);
    rdy.slow_ready <= 1'b1;
    cyc(4);
    chk(src, 2);
    rd(8'h97, 8'h01, 8'h00);
    rd(8'hF0, 8'h02, 8'h02);
    chk(irq, 0);
    wr(8'hF0, 8'h03);
  endtask
  task automatic t_fast;
    pw(8'h97, 8'h10);
    cyc(2);
    chk(fon, 0);
    in_app_programming <= 1'b1;
    cyc(2);
    chk(fon, 1);
    rd(8'h97, 8'hFF, 8'h30);
    rd(8'h96, 8'h20, 8'h20);
    in_app_programming <= 1'b0;
    cyc(2);
    chk(fon, 0);
    rd(8'h97, 8'hFF, 8'h10);
    rd(8'h96, 8'h20, 8'h00);
    pw(8'h97, 8'h30);
    pw(8'h96, 8'h00);
    cyc(3);
    chk(src, 0);
    pw(8'h97, 8'h10);
    rd(8'h97, 8'hFF, 8'h30);
    pw(8'h97, 8'hF0);
    pw(8'h96, 8'h02);
    cyc(3);
    chk(src, 1);
    pw(8'h96, 8'h06);
    cyc(3);
    chk(src, 1);
  endtask
  task automatic t_clock;
    logic p;
    wr(8'h8E, 8'h02);
    cyc(2);
    chk(oe, 1);
    per(8'h00);
    per(8'h03);
    per(8'hFF);
    per(8'h01);
    pd <= 1'b1;
    cyc(3);
    p = pin;
    repeat (20) begin
      @(posedge clk_i);
      chk(pin, p);
    end
    pd <= 1'b0;
    wr(8'h8E, 8'h00);
    cyc(2);
    chk({oe, pin}, 0);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_switch;
    t_fast;
    t_clock;
    give_verdict;
  end
  initial begin
    #500000;
    n_mismatch++;
    give_verdict;
  end
endmodule // tb_csd_clock_ctrl
